// File: core/dpram_consts.svh
// constants for the dual-port block memory
// assumes inclusion by bare name from package and modules
`ifndef DPRAM_CONSTS_SVH
`define DPRAM_CONSTS_SVH
`define RAM_BITS       4096
`define RAM_ADDR_BITS  12
`define PORT_DATA_MAX  16
`define CLK_PERIOD_NS  50
`endif

// File: core/dpram_pkg.sv
// types shared by the dual-port block memory
// assumes dpram_consts.svh on the include path
`include "dpram_consts.svh"
package dpram_pkg;
  typedef logic [`RAM_ADDR_BITS-1:0] bit_addr_t;
  typedef logic [`PORT_DATA_MAX-1:0] port_data_t;
  typedef struct packed {
    logic                      en;
    logic                      we;
    logic [`RAM_ADDR_BITS-1:0] addr;
    logic [`PORT_DATA_MAX-1:0] wdata;
  } port_req_s;
endpackage

// File: core/dpram_port.sv
// one port of the block memory: request capture and bit-address mapping
// assumes the memory array lives in the parent and a single shared clock
`timescale 1ns/10ps
`include "dpram_consts.svh"
module dpram_port
  import dpram_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  en_i,
  input  wire logic                  we_i,
  input  wire logic [`RAM_ADDR_BITS-1:0] addr_i,
  input  wire logic [WIDTH-1:0]      data_i,
  output port_req_s                  req_o
);
  localparam int AW = $clog2(`RAM_BITS / WIDTH); // RL4

  // only the five port shapes map cleanly onto the bit array
  if (!(WIDTH == 1 || WIDTH == 2 || WIDTH == 4 || WIDTH == 8 || WIDTH == 16)) begin : g_bad_width
    $error("dpram_port: WIDTH must be 1, 2, 4, 8 or 16");
  end

  port_req_s req_next;

  // word a at width w starts at bit a*w
  function automatic bit_addr_t word_to_bit(input logic [`RAM_ADDR_BITS-1:0] a);
    word_to_bit = bit_addr_t'(a[AW-1:0] * WIDTH); // RL5
  endfunction

  always_comb begin
    req_next       = '0;
    req_next.en    = en_i;
    req_next.we    = en_i & we_i;
    req_next.addr  = word_to_bit(addr_i);
    req_next.wdata = port_data_t'(data_i);
  end

  // pure registering keeps access synchronous to the port clock
  always_ff @(posedge clk_i) begin
    req_o <= req_next; // RL1
  end

  logic unused;
  assign unused = rst_i;
endmodule // dpram_port

// File: core/dpram_top.sv
// dual-port 4096-bit block memory with independent port widths
// assumes one clock for both ports; the fabric drives each port
//
// Summary of operation
// [RL1] 4096 bits, two ports, synchronous access
// [RL2] independent control signals per port
// [RL3] per-port width gives bus-width conversion
// [RL4] widths 1, 2, 4, 8 or 16 with matching depths
// [RL5] word a maps to bits a*w onward
`timescale 1ns/10ps
`include "dpram_consts.svh"
module dpram_top
  import dpram_pkg::*;
#(
  parameter int WIDTH_A = 16,
  parameter int WIDTH_B = 1
) (
  input  wire logic                      CLK_I,
  input  wire logic                      RST_I,
  input  wire logic                      EN_A_I,
  input  wire logic                      WE_A_I,
  input  wire logic [`RAM_ADDR_BITS-1:0] ADDR_A_I,
  input  wire logic [WIDTH_A-1:0]        DATA_A_I,
  output logic      [WIDTH_A-1:0]        DATA_A_O,
  input  wire logic                      EN_B_I,
  input  wire logic                      WE_B_I,
  input  wire logic [`RAM_ADDR_BITS-1:0] ADDR_B_I,
  input  wire logic [WIDTH_B-1:0]        DATA_B_I,
  output logic      [WIDTH_B-1:0]        DATA_B_O
);
  // memory contents, one bit per entry so any width pair lines up
  logic [`RAM_BITS-1:0] mem_reg;
  logic [`RAM_BITS-1:0] mem_next;
  logic [WIDTH_A-1:0]   rd_a_reg;
  logic [WIDTH_A-1:0]   rd_a_next;
  logic [WIDTH_B-1:0]   rd_b_reg;
  logic [WIDTH_B-1:0]   rd_b_next;
  port_req_s            req_a;
  port_req_s            req_b;

  dpram_port #(.WIDTH(WIDTH_A)) u_port_a ( // RL2
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .en_i   (EN_A_I),
    .we_i   (WE_A_I),
    .addr_i (ADDR_A_I),
    .data_i (DATA_A_I),
    .req_o  (req_a)
  );

  dpram_port #(.WIDTH(WIDTH_B)) u_port_b ( // RL2
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .en_i   (EN_B_I),
    .we_i   (WE_B_I),
    .addr_i (ADDR_B_I),
    .data_i (DATA_B_I),
    .req_o  (req_b)
  );

  // address bits above the port depth are ignored (RL4 shapes)
  always_comb begin
    mem_next  = mem_reg;
    rd_a_next = rd_a_reg;
    rd_b_next = rd_b_reg;
    if (req_a.en) begin
      for (int i = 0; i < WIDTH_A; i++) begin
        rd_a_next[i] = mem_reg[req_a.addr + bit_addr_t'(i)]; // RL3
      end
    end
    if (req_b.en) begin
      for (int i = 0; i < WIDTH_B; i++) begin
        rd_b_next[i] = mem_reg[req_b.addr + bit_addr_t'(i)]; // RL3
      end
    end
    // read-before-write; on a collision port b's write lands last
    if (req_a.we) begin
      for (int i = 0; i < WIDTH_A; i++) begin
        mem_next[req_a.addr + bit_addr_t'(i)] = req_a.wdata[i]; // RL1
      end
    end
    if (req_b.we) begin
      for (int i = 0; i < WIDTH_B; i++) begin
        mem_next[req_b.addr + bit_addr_t'(i)] = req_b.wdata[i]; // RL1
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    mem_reg <= mem_next;
    if (RST_I) begin
      rd_a_reg <= '0;
      rd_b_reg <= '0;
    end else begin
      rd_a_reg <= rd_a_next;
      rd_b_reg <= rd_b_next;
    end
  end

  assign DATA_A_O = rd_a_reg;
  assign DATA_B_O = rd_b_reg;
endmodule // dpram_top

// File: sim/dpram_properties.sv
// checker: port timing of the block memory
// assumes bind onto dpram_top
`timescale 1ns/10ps
module dpram_properties #(
  parameter int WIDTH_A = 16,
  parameter int WIDTH_B = 1
) (
  input  wire logic               CLK_I,
  input  wire logic               RST_I,
  input  wire logic               EN_A_I,
  input  wire logic               WE_A_I,
  input  wire logic [11:0]        ADDR_A_I,
  input  wire logic [WIDTH_A-1:0] DATA_A_I,
  input  wire logic [WIDTH_A-1:0] DATA_A_O,
  input  wire logic               EN_B_I,
  input  wire logic               WE_B_I,
  input  wire logic [11:0]        ADDR_B_I,
  input  wire logic [WIDTH_B-1:0] DATA_B_I,
  input  wire logic [WIDTH_B-1:0] DATA_B_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence wr_a; EN_A_I && WE_A_I && !WE_B_I; endsequence
  sequence rd_a; EN_A_I && !WE_A_I && !WE_B_I && $stable(ADDR_A_I); endsequence
  a_wr_rd_a: assert property (wr_a ##1 rd_a |-> ##2 DATA_A_O == $past(DATA_A_I, 3))
    else $error("a readback");
  a_hold_a: assert property (!EN_A_I |-> ##2 $stable(DATA_A_O))
    else $error("a moved");
  a_hold_b: assert property (!EN_B_I |-> ##2 $stable(DATA_B_O))
    else $error("b moved");
  a_rst_a: assert property ($fell(RST_I) |-> DATA_A_O == '0)
    else $error("a not cleared");
  a_rst_b: assert property ($fell(RST_I) |-> DATA_B_O == '0)
    else $error("b not cleared");
endmodule // dpram_properties
bind dpram_top dpram_properties #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B)) u_props (.*);

// File: sim/fab_b.sv
// fabric logic on port b
// assumes calls made at falling edges
`timescale 1ns/10ps
module fab_b (
  input  wire logic        clk_i,
  output logic             en_o,
  output logic             we_o,
  output logic             d_o,
  output logic [11:0]      a_o
);
  initial {en_o, we_o, d_o, a_o} = '0;
  task automatic acc(logic w, logic [11:0] a, logic d);
    {en_o, we_o, a_o, d_o} = {1'b1, w, a, d};
    @(negedge clk_i);
  endtask
  // released data flips so stale bits fail
  task automatic rel;
    {en_o, we_o, d_o} = {2'b00, ~d_o};
    @(negedge clk_i);
  endtask
endmodule // fab_b

// File: sim/tb_top.sv
// bench: block memory, widths 16 and 1
// assumes fab_b on port b
`timescale 1ns/10ps
module tb_top;
  localparam logic [15:0] P1 = 16'ha5c3, P2 = 16'h3c5a;
  logic clk = 0, rst = 1, en_a = 0, we_a = 0, en_b, we_b, db, qb;
  logic [11:0] ad_a = '0, ad_b;
  logic [15:0] da = '0, qa;
  int err_total = 0, total_checks = 0, cyc = 0;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 400) begin
      err_total++;
      final_report();
    end
  end
  dpram_top u_dut (.CLK_I(clk), .RST_I(rst), .EN_A_I(en_a), .WE_A_I(we_a), .ADDR_A_I(ad_a),
    .DATA_A_I(da), .DATA_A_O(qa), .EN_B_I(en_b), .WE_B_I(we_b), .ADDR_B_I(ad_b),
    .DATA_B_I(db), .DATA_B_O(qb));
  fab_b u_fab (.clk_i(clk), .en_o(en_b), .we_o(we_b), .d_o(db), .a_o(ad_b));
  task chk(string n, logic [15:0] e, s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task acc_a(logic w, logic [11:0] a, logic [15:0] d);
    {en_a, we_a, ad_a, da} = {1'b1, w, a, d};
    @(negedge clk);
  endtask
  task idle_a;
    {en_a, we_a, da} = {2'b00, ~da};
    @(negedge clk);
  endtask
  task t_conv;
    acc_a(1, 12'h003, P1);
    acc_a(0, 12'h003, 0);
    idle_a();
    chk("a", P1, qa);
    for (int i = 0; i < 16; i++) begin
      u_fab.acc(0, 12'd48 + 12'(i), 0);
      u_fab.rel();
      chk("b", 16'(P1[i]), 16'(qb));
    end
  endtask
  // both ports in one cycle: a reads old word 3 while b rewrites its bit 0
  task t_both;
    {en_a, we_a, ad_a, da} = {1'b1, 1'b0, 12'h003, 16'h0};
    u_fab.acc(1, 12'd48, ~P1[0]);
    en_a = 1'b0;
    u_fab.rel();
    chk("a old", P1, qa);
    acc_a(0, 12'h003, 0);
    idle_a();
    chk("a new", P1 ^ 16'h0001, qa);
  endtask
  task t_b2a;
    // last word of the array, seen from both ports
    acc_a(1, 12'hfff, P1);
    acc_a(0, 12'hfff, 0);
    idle_a();
    chk("a top", P1, qa);
    u_fab.acc(0, 12'hfff, 0);
    u_fab.rel();
    chk("b top", 16'(P1[15]), 16'(qb));
    // preset word 1 to ~P2 so any bit that port b fails to write shows up in port a's read
    acc_a(1, 12'h001, ~P2);
    acc_a(0, 12'h001, 0);
    idle_a();
    chk("a pre", ~P2, qa);
    for (int i = 0; i < 16; i++) u_fab.acc(1, 12'd16 + 12'(i), P2[i]);
    u_fab.rel();
    acc_a(0, 12'h001, 0);
    idle_a();
    chk("a wide", P2, qa);
  endtask
  task t_hold;
    {we_a, da, ad_a} = {1'b1, 16'h0, 12'h001};
    repeat (3) @(negedge clk);
    chk("a hold", P2, qa);
    acc_a(0, 12'h001, 0);
    idle_a();
    chk("a off", P2, qa);
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    @(negedge clk);
    chk("a rst", 16'h0, qa);
    chk("b rst", 16'h0, 16'(qb));
    t_conv();
    t_both();
    t_b2a();
    t_hold();
    final_report();
  end
endmodule // tb_top
